// [iomh_pkg.sv]
package iomh_pkg;
  // ---------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 12;
  localparam int UNIT_W = 4;
  localparam logic [3:0] CTRL_ADDR = 4'hf;
  localparam int BIT_TME = 4;
  localparam int BIT_SYE = 5;
  localparam int BIT_DTE = 6;
  localparam int BIT_ISL = 7;
  localparam int BIT_IEN = 8;
  localparam int NUM_SLOTS = 15;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_LASTWORD = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int STROBE_DELAY_NS = 2000;
  localparam int STROBE_DELAY_CYC = (STROBE_DELAY_NS * CLK_MHZ) / 1000;
  localparam int STROBE_MIN_CYC = 4;
  localparam int CNT_W = 12;
  typedef enum logic [2:0] {
    IOMH_IDLE, IOMH_WAIT, IOMH_STROBE, IOMH_RELEASE, IOMH_BUSY
  } iomh_state_t;
endpackage

// [iomh_port.sv]
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module iomh_port
  import iomh_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Controller side
  input wire logic [iomh_pkg::ADDR_W-1:0] word_addr,
  input wire logic [iomh_pkg::DATA_W-1:0] word_data,
  input wire logic gate_request_n,
  output logic flag_return_n,
  output logic [iomh_pkg::DATA_W-1:0] return_data,
  output logic return_b15,
  // Backplane side
  input wire logic common_timing_flag_n,
  input wire logic [iomh_pkg::DATA_W-1:0] card_in_data,
  input wire logic input_request,
  input wire logic chain_ok,
  output logic data_strobe_pulse,
  output logic [iomh_pkg::ADDR_W-1:0] slot_addr,
  output logic [iomh_pkg::UNIT_W-1:0] unit_select,
  output logic [iomh_pkg::DATA_W-1:0] slot_data,
  output logic timing_mode_select,
  output logic system_output_enable,
  output logic sync_transfer_enable,
  output logic input_direction_select,
  output logic interrupt_arm_enable,
  output logic ctf_drive_n,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import iomh_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Gate, timing flag and chain status come from cables.
  logic [2:0] sync1_reg, sync2_reg, sync1_next, sync2_next;
  logic gate_prev_reg, gate_prev_next;
  logic [DATA_W-1:0] in1_reg, in2_reg, in1_next, in2_next;
  logic irq1_reg, irq2_reg, irq1_next, irq2_next;
  logic [ADDR_W-1:0] a1_reg, a2_reg, a1_next, a2_next;
  logic [DATA_W-1:0] d1_reg, d2_reg, d1_next, d2_next;

  always_comb begin
    sync1_next = {chain_ok, common_timing_flag_n, gate_request_n};
    sync2_next = sync1_reg;
    gate_prev_next = sync2_reg[0];
    in1_next = card_in_data;
    in2_next = in1_reg;
    irq1_next = input_request;
    irq2_next = irq1_reg;
    a1_next = word_addr;
    a2_next = a1_reg;
    d1_next = word_data;
    d2_next = d1_reg;
    if (rst) begin
      sync1_next = 3'h3;
      sync2_next = 3'h3;
      gate_prev_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    sync1_reg <= sync1_next;
    sync2_reg <= sync2_next;
    gate_prev_reg <= gate_prev_next;
    in1_reg <= in1_next;
    in2_reg <= in2_next;
    irq1_reg <= irq1_next;
    irq2_reg <= irq2_next;
    a1_reg <= a1_next;
    a2_reg <= a2_next;
    d1_reg <= d1_next;
    d2_reg <= d2_next;
  end

  logic gate_low, gate_fall, ctf_low, chain_good;
  assign gate_low = ~sync2_reg[0];
  assign gate_fall = gate_prev_reg & ~sync2_reg[0];
  assign ctf_low = ~sync2_reg[1];
  assign chain_good = sync2_reg[2];

  // ---------------------------------------------------------------
  // Handshake state machine
  // ---------------------------------------------------------------
  iomh_state_t st_reg, st_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic strobe_reg, strobe_next;
  logic flag_n_reg, flag_n_next;
  logic busy_reg, busy_next;
  logic [ADDR_W-1:0] sa_reg, sa_next;
  logic [DATA_W-1:0] sd_reg, sd_next;
  logic [UNIT_W-1:0] unit_reg, unit_next;
  logic [4:0] mode_reg, mode_next;
  logic ctff_n_reg, ctff_n_next;
  logic [15:0] last_reg, last_next;
  logic [7:0] xfer_cnt_reg, xfer_cnt_next;
  logic sw_preset_reg;
  logic auto_flag_n;

  // Leading flag edge trails the strobe by one cycle so the controller never
  // sees processing start before the slots were strobed
  assign auto_flag_n = ~((st_reg == IOMH_STROBE && strobe_reg) || st_reg == IOMH_RELEASE);

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    strobe_next = 1'b0;
    busy_next = busy_reg;
    sa_next = sa_reg;
    sd_next = sd_reg;
    unit_next = unit_reg;
    mode_next = mode_reg;
    ctff_n_next = ctff_n_reg;
    last_next = last_reg;
    xfer_cnt_next = xfer_cnt_reg;
    case (st_reg)
      IOMH_IDLE: begin
        if (gate_fall) begin
          st_next = IOMH_WAIT;
          cnt_next = '0;
          sa_next = a2_reg;
        end
      end
      IOMH_WAIT: begin
        cnt_next = cnt_reg + 12'h001;
        if (cnt_reg == CNT_W'(STROBE_DELAY_CYC - 1)) begin
          st_next = IOMH_STROBE;
          cnt_next = '0;
          last_next = {a2_reg, d2_reg};
          sa_next = a2_reg;
          // Input select leaves the data lines holding their last latched word
          if (!mode_reg[3]) begin
            sd_next = d2_reg;
          end
          if (a2_reg == CTRL_ADDR) begin
            unit_next = d2_reg[UNIT_W-1:0];
            mode_next = d2_reg[BIT_IEN:BIT_TME];
            // Timing flip-flop pulls the shared line unless arm is set
            ctff_n_next = d2_reg[BIT_IEN];
          end
          xfer_cnt_next = xfer_cnt_reg + 8'h01;
        end
      end
      IOMH_STROBE: begin
        strobe_next = 1'b1;
        cnt_next = (cnt_reg == CNT_W'(STROBE_MIN_CYC)) ? cnt_reg : cnt_reg + 12'h001;
        if (!gate_low && cnt_reg == CNT_W'(STROBE_MIN_CYC)) begin
          st_next = IOMH_RELEASE;
          strobe_next = 1'b0;
          cnt_next = '0;
        end
      end
      IOMH_RELEASE: begin
        // Processing time after strobe end, then trailing flag edge
        cnt_next = cnt_reg + 12'h001;
        ctff_n_next = 1'b1;
        if (cnt_reg == CNT_W'(STROBE_MIN_CYC)) begin
          st_next = IOMH_IDLE;
        end
      end
      default: begin
        st_next = IOMH_IDLE;
      end
    endcase
    busy_next = (st_next != IOMH_IDLE);
    if (rst || sw_preset_reg) begin
      st_next = IOMH_IDLE;
      cnt_next = '0;
      strobe_next = 1'b0;
      busy_next = 1'b0;
      sa_next = '0;
      sd_next = '0;
      unit_next = '0;
      mode_next = '0;
      ctff_n_next = 1'b1;
      last_next = '0;
      xfer_cnt_next = '0;
    end
  end

  // Flag follows the shared timing line in timing mode
  always_comb begin
    if (mode_reg[0]) begin
      flag_n_next = ~(ctf_low | ~ctff_n_reg);
    end else begin
      flag_n_next = auto_flag_n;
    end
    if (rst) begin
      flag_n_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
    cnt_reg <= cnt_next;
    strobe_reg <= strobe_next;
    flag_n_reg <= flag_n_next;
    busy_reg <= busy_next;
    sa_reg <= sa_next;
    sd_reg <= sd_next;
    unit_reg <= unit_next;
    mode_reg <= mode_next;
    ctff_n_reg <= ctff_n_next;
    last_reg <= last_next;
    xfer_cnt_reg <= xfer_cnt_next;
  end

  // ---------------------------------------------------------------
  // Broadcast outputs and return path
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] ret_next;
  logic ret15_next;
  logic sye_next;

  always_comb begin
    // Input data is presented without any handshake
    ret_next = mode_reg[3] ? in2_reg : d2_reg;
    ret15_next = mode_reg[3] ? irq2_reg : a2_reg[3];
    // Chain break drops enable; latched data stays put
    sye_next = mode_reg[1] & chain_good;
    if (rst) begin
      ret_next = '0;
      ret15_next = 1'b0;
      sye_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    return_data <= ret_next;
    return_b15 <= ret15_next;
    system_output_enable <= sye_next;
  end

  // Mode bits go to every slot, never gated by slot or unit address
  assign timing_mode_select = mode_reg[0];
  assign sync_transfer_enable = mode_reg[2];
  assign input_direction_select = mode_reg[3];
  assign interrupt_arm_enable = mode_reg[4];
  assign flag_return_n = flag_n_reg;
  assign data_strobe_pulse = strobe_reg;
  assign slot_addr = sa_reg;
  assign slot_data = sd_reg;
  assign unit_select = unit_reg;
  assign ctf_drive_n = ctff_n_reg;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic bv_reg, bv_next, rv_reg, rv_next;
  logic [1:0] br_reg, br_next, rr_reg, rr_next;
  logic [31:0] rd_reg, rd_next;
  logic sw_preset_next;

  always_comb begin
    aw_hold_next = aw_hold_reg;
    w_hold_next = w_hold_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    bv_next = bv_reg;
    br_next = br_reg;
    rv_next = rv_reg;
    rr_next = rr_reg;
    rd_next = rd_reg;
    sw_preset_next = 1'b0;
    if (s_axi_awvalid && !aw_hold_reg && !bv_reg) begin
      aw_hold_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_reg && !bv_reg) begin
      w_hold_next = 1'b1;
      wd_next = s_axi_wdata;
    end
    if (aw_hold_reg && w_hold_reg && !bv_reg) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bv_next = 1'b1;
      br_next = RESP_SLVERR;
      if (awa_reg == OFF_CTRL) begin
        br_next = RESP_OKAY;
        // Writing bit 0 presets the port as at power-up
        sw_preset_next = wd_reg[0];
      end
    end else if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    if (s_axi_arvalid && !rv_reg) begin
      rv_next = 1'b1;
      rr_next = RESP_OKAY;
      case (s_axi_araddr)
        OFF_CTRL: rd_next = 32'h0;
        OFF_STATUS: rd_next = {8'h0, xfer_cnt_reg, unit_reg, 2'h0, busy_reg,
                               chain_good, 3'h0, mode_reg};
        OFF_LASTWORD: rd_next = {16'h0, last_reg};
        default: begin
          rd_next = 32'h0;
          rr_next = RESP_SLVERR;
        end
      endcase
    end else if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
    if (rst) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      awa_next = '0;
      wd_next = '0;
      bv_next = 1'b0;
      br_next = RESP_OKAY;
      rv_next = 1'b0;
      rr_next = RESP_OKAY;
      rd_next = '0;
      sw_preset_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    aw_hold_reg <= aw_hold_next;
    w_hold_reg <= w_hold_next;
    awa_reg <= awa_next;
    wd_reg <= wd_next;
    bv_reg <= bv_next;
    br_reg <= br_next;
    rv_reg <= rv_next;
    rr_reg <= rr_next;
    rd_reg <= rd_next;
    sw_preset_reg <= sw_preset_next;
  end

  assign s_axi_awready = !aw_hold_reg && !bv_reg;
  assign s_axi_wready = !w_hold_reg && !bv_reg;
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = br_reg;
  assign s_axi_arready = !rv_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rresp = rr_reg;
  assign s_axi_rdata = rd_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Delay too long for a plain cycle delay, so the wait is counted here
  logic [CNT_W-1:0] wait_len_reg, wait_len_next;

  always_comb begin
    wait_len_next = wait_len_reg;
    if (st_reg == IOMH_WAIT) begin
      wait_len_next = wait_len_reg + 12'h001;
    end else if (st_reg == IOMH_IDLE) begin
      wait_len_next = '0;
    end
    if (rst) begin
      wait_len_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    wait_len_reg <= wait_len_next;
  end

  property p_strobe_delay;
    @(posedge clk) disable iff (rst)
      $rose(strobe_reg) |-> (wait_len_reg == CNT_W'(STROBE_DELAY_CYC));
  endproperty
  a_strobe_delay: assert property (p_strobe_delay) else $error("strobe late");

  property p_no_early_strobe;
    @(posedge clk) disable iff (rst)
      $rose(gate_low) |-> !strobe_reg [*8];
  endproperty
  a_no_early_strobe: assert property (p_no_early_strobe) else $error("strobe early");

  property p_flag_auto;
    @(posedge clk) disable iff (rst)
      (strobe_reg && !mode_reg[0]) |=> !flag_return_n;
  endproperty
  a_flag_auto: assert property (p_flag_auto) else $error("no flag edge");

  property p_strobe_end;
    @(posedge clk) disable iff (rst)
      (strobe_reg && !gate_low && cnt_reg == CNT_W'(STROBE_MIN_CYC)) |=> !strobe_reg;
  endproperty
  a_strobe_end: assert property (p_strobe_end) else $error("strobe not ended");

  property p_flag_ctf;
    @(posedge clk) disable iff (rst)
      (mode_reg[0] && ctf_low) |=> !flag_return_n;
  endproperty
  a_flag_ctf: assert property (p_flag_ctf) else $error("flag ignores ctf");

  property p_sye_chain;
    @(posedge clk) disable iff (rst)
      !chain_good |=> !system_output_enable;
  endproperty
  a_sye_chain: assert property (p_sye_chain) else $error("sye with broken chain");

  property p_ctrl_only;
    @(posedge clk) disable iff (rst)
      (st_reg == IOMH_WAIT && a2_reg != CTRL_ADDR && !sw_preset_reg) |=> $stable(mode_reg);
  endproperty
  a_ctrl_only: assert property (p_ctrl_only) else $error("mode changed");

  property p_hold;
    @(posedge clk) disable iff (rst)
      (st_reg == IOMH_IDLE && !sw_preset_reg) |=> $stable(sd_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("data not held");

  property p_isl;
    @(posedge clk) disable iff (rst)
      (mode_reg[3] && st_reg != IOMH_IDLE && !sw_preset_reg) |=> $stable(sd_reg);
  endproperty
  a_isl: assert property (p_isl) else $error("output data passed in input mode");
endmodule
`default_nettype wire

// [iomh_ctl_model.sv]
`timescale 1ns/100ps
`default_nettype none
module iomh_ctl_model
  import iomh_pkg::*;
(
  // Clock
  input wire logic clk,
  // Word lines and handshake
  output logic [iomh_pkg::ADDR_W-1:0] word_addr,
  output logic [iomh_pkg::DATA_W-1:0] word_data,
  output logic gate_request_n,
  input wire logic flag_return_n
);
  initial begin
    word_addr = '0;
    word_data = '0;
    gate_request_n = 1'b1;
  end

  // ---------------------------------------------------------------
  // One gated output cycle
  // ---------------------------------------------------------------
  task automatic send(input logic [3:0] a, input logic [11:0] d, output logic ok);
    int n;
    int m;
    @(posedge clk);
    word_addr <= a;
    word_data <= d;
    @(posedge clk);
    gate_request_n <= 1'b0;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (flag_return_n === 1'b0) break;
    end
    gate_request_n <= 1'b1;
    // Lines are no longer held once processing has begun
    word_addr <= ~a;
    word_data <= ~d;
    for (m = 0; m < 3000; m++) begin
      @(posedge clk);
      if (flag_return_n === 1'b1) break;
    end
    ok = (n < 3000) && (m < 3000);
  endtask
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb;
  import iomh_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] word_addr;
  logic [11:0] word_data, return_data, card_in_data, slot_data;
  logic gate_request_n, flag_return_n, return_b15, common_timing_flag_n, input_request;
  logic chain_ok, data_strobe_pulse, ctf_drive_n;
  logic [3:0] slot_addr, unit_select;
  logic timing_mode_select, system_output_enable, sync_transfer_enable;
  logic input_direction_select, interrupt_arm_enable;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ok, strobe_q, flag_q, gate_q;
  logic strobe_at_rel;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int gcnt = 0;
  int strobe_at = 0;
  int flag_at = 0;
  logic [4:0] modes;
  assign modes = {interrupt_arm_enable, input_direction_select, sync_transfer_enable,
    system_output_enable, timing_mode_select};

  iomh_port u_dut (.clk, .rst, .word_addr, .word_data, .gate_request_n, .flag_return_n,
    .return_data, .return_b15, .common_timing_flag_n, .card_in_data, .input_request,
    .chain_ok, .data_strobe_pulse, .slot_addr, .unit_select, .slot_data, .timing_mode_select,
    .system_output_enable, .sync_transfer_enable, .input_direction_select,
    .interrupt_arm_enable, .ctf_drive_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  iomh_ctl_model u_ctl (.clk, .word_addr, .word_data, .gate_request_n, .flag_return_n);

  always #2.5 clk = ~clk;

  // ---------------------------------------------------------------
  // Handshake monitor and timeout
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    strobe_q <= data_strobe_pulse;
    flag_q <= flag_return_n;
    gate_q <= gate_request_n;
    gcnt <= gate_request_n ? 0 : gcnt + 1;
    if (data_strobe_pulse && !strobe_q) strobe_at <= gcnt;
    if (!flag_return_n && flag_q) flag_at <= gcnt;
    if (gate_request_n && !gate_q) strobe_at_rel <= data_strobe_pulse;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic word(input logic [3:0] a, input logic [11:0] d);
    u_ctl.send(a, d, ok);
    `CHK("handshake_done", 1'b1, ok);
    `CHK("strobe_end", 1'b0, data_strobe_pulse);
  endtask

  task automatic final_report();
    $display("mismatches %0d of %0d comparisons", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int b;
    {common_timing_flag_n, chain_ok} = 2'b11;
    {card_in_data, input_request, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("flag_idle", 1'b1, flag_return_n);
    `CHK("sye_preset", 1'b0, system_output_enable);
    word(4'h3, 12'ha5c);
    `CHK("strobe_delay", 1'b1, strobe_at >= STROBE_DELAY_CYC && strobe_at <= STROBE_DELAY_CYC + 8);
    `CHK("flag_after_strobe", 1'b1, flag_at > strobe_at);
    `CHK("strobe_at_release", 1'b1, strobe_at_rel);
    `CHK("slot_addr", 4'h3, slot_addr);
    `CHK("slot_data", 12'ha5c, slot_data);
    axi_read(OFF_LASTWORD);
    `CHK("lastword", 32'h00003a5c, rd);
    axi_read(8'h0c);
    `CHK("unmapped_resp", RESP_SLVERR, rsp);
    `CHK("unmapped_data", 32'h00000000, rd);
    for (b = BIT_TME; b <= BIT_IEN; b++) begin
      word(CTRL_ADDR, (12'h001 << b) | 12'h005);
      `CHK("mode_bits", 5'h01 << (b - BIT_TME), modes);
      `CHK("unit", 4'h5, unit_select);
      axi_read(OFF_STATUS);
      `CHK("status_modes", 5'h01 << (b - BIT_TME), rd[4:0]);
    end
    word(CTRL_ADDR, 12'h065);
    word(4'h2, 12'h1f0);
    `CHK("modes_kept", 5'h06, modes);
    `CHK("unit_kept", 4'h5, unit_select);
    `CHK("slot_data2", 12'h1f0, slot_data);
    axi_write(OFF_CTRL, 32'h00000001);
    `CHK("ctrl_resp", RESP_OKAY, rsp);
    repeat (2) @(posedge clk);
    `CHK("sye_cleared", 1'b0, system_output_enable);
    word(CTRL_ADDR, 12'h015);
    fork
      word(4'h1, 12'h123);
      begin
        for (b = 0; b < 1000 && !data_strobe_pulse; b++) @(posedge clk);
        common_timing_flag_n <= 1'b0;
        repeat (30) @(posedge clk);
        `CHK("flag_follows_low", 1'b0, flag_return_n);
        common_timing_flag_n <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK("flag_follows_high", 1'b1, flag_return_n);
      end
    join
    `CHK("ctf_released", 1'b1, ctf_drive_n);
    word(CTRL_ADDR, 12'h085);
    card_in_data <= 12'h3c6;
    input_request <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("return_data", 12'h3c6, return_data);
    `CHK("return_b15", 1'b1, return_b15);
    word(4'h4, 12'h777);
    `CHK("addr_active", 4'h4, slot_addr);
    `CHK("data_blocked", 1'b1, slot_data !== 12'h777);
    chain_ok <= 1'b0;
    repeat (6) @(posedge clk);
    axi_read(OFF_STATUS);
    `CHK("chain_status", 1'b0, rd[8]);
    final_report();
  end
endmodule
`default_nettype wire
